// File: rtl/sdram_cfg.svh
// sdram_cfg.svh: sizes, command codes and timing counts for both ends
// assumes one 100 MHz mclk shared by the controller and the memory end
`ifndef SDRAM_CFG_SVH
`define SDRAM_CFG_SVH
`define CLK_NS       10
`define T_RCD_NS     20
`define T_RP_NS      20
`define T_WR_NS      15
`define T_RAS_NS     45
`define T_RFC_NS     72
`define T_XSR_NS     120
`define T_REF_MS     64
`define REF_ROWS     4096
`define CYC_UP(t)    ((((t) + `CLK_NS) - 1) / `CLK_NS)
`define RCD_CYC      `CYC_UP(`T_RCD_NS)
`define RP_CYC       `CYC_UP(`T_RP_NS)
`define WR_CYC       `CYC_UP(`T_WR_NS)
`define RAS_CYC      `CYC_UP(`T_RAS_NS)
`define RFC_CYC      `CYC_UP(`T_RFC_NS)
`define XSR_RAW      `CYC_UP(`T_XSR_NS)
`define XSR_CYC      ((`XSR_RAW < 2) ? 2 : `XSR_RAW)
`define REFI_CYC     (((`T_REF_MS * 1000000) / `REF_ROWS) / `CLK_NS)
`define BURST_LEN    4
`define READ_LATENCY 2
`define MEM_WORDS    32
`define CMD_NOP      4'h7
`define CMD_ACT      4'h3
`define CMD_READ     4'h5
`define CMD_WRITE    4'h4
`define CMD_PRE      4'h2
`define CMD_REF      4'h1
`define CMD_BST      4'h6
`define A10_ALL      12'h400
`endif

// File: rtl/sdram_pkg.sv
// sdram_pkg: types shared by both ends of the link
// assumes sdram_cfg.svh for the numbers
`include "sdram_cfg.svh"
package sdram_pkg;
   typedef logic [11:0] cnt_t;
   typedef enum logic [1:0] {
      P_NORMAL = 2'b00,
      P_PDOWN  = 2'b01,
      P_SELF   = 2'b10,
      P_DEEP   = 2'b11
   } pwr_e;
   typedef enum logic [3:0] {
      C_IDLE   = 4'b0000,
      C_WAIT   = 4'b0001,
      C_RW     = 4'b0010,
      C_PRE    = 4'b0011,
      C_REF    = 4'b0100,
      C_SENTER = 4'b0101,
      C_SREF   = 4'b0110,
      C_DENTER = 4'b0111,
      C_DEEP   = 4'b1000,
      C_PDN    = 4'b1001
   } ctl_e;
endpackage

// File: rtl/sdram_link_if.sv
// sdram_link_if: command, CKE, DQM and split DQ between the two ends
// assumes the bench resolves the DQ wire from the two enables
`timescale 1ns/1ps
interface sdram_link_if;
   logic        csN;
   logic        rasN;
   logic        casN;
   logic        weN;
   logic        cke;
   logic        dqm;
   logic [1:0]  ba;
   logic [11:0] addr;
   logic [15:0] dqWr;
   logic        dqWrOe;
   logic [15:0] dqRd;
   logic        dqRdOe;
   modport ctrl (output csN, rasN, casN, weN, cke, dqm, ba, addr,
                 output dqWr, dqWrOe, input dqRd, dqRdOe);
   modport mem  (input csN, rasN, casN, weN, cke, dqm, ba, addr,
                 input dqWr, dqWrOe, output dqRd, dqRdOe);
endinterface

// File: rtl/sdram_mem_end.sv
// sdram_mem_end: memory end, command decode, bursts and power states
// assumes the controller keeps its own timing; one small word array
`timescale 1ns/1ps
`include "sdram_cfg.svh"
module sdram_mem_end (
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             rst_n,
   // link to the controller
   sdram_link_if.mem             link,
   // status
   output sdram_pkg::pwr_e       powerMode,
   output logic                  activePd,
   output logic                  suspended,
   output logic [11:0]           refreshRow,
   output logic [3:0]            banksOpen
);
   import sdram_pkg::*;

   localparam int BL = `BURST_LEN;
   localparam int RL = `READ_LATENCY;

   pwr_e        pwr_q;
   logic        ckeReg_q;
   logic        activePd_q;
   logic        suspended_q;
   logic [3:0]  banksOut_q;
   logic        bActive_q;
   logic        bWrite_q;
   logic        bAp_q;
   logic [1:0]  bBank_q;
   logic [2:0]  bCol_q;
   logic [2:0]  bLeft_q;
   logic [15:0] mem_q [`MEM_WORDS];
   logic [15:0] pipeD_q [RL];
   logic [RL-1:0] pipeV_q;
   logic [11:0] refRow_q;
   cnt_t        selfTick_q;
   wire  [3:0]  bankOpen;
   wire  [3:0]  wrBusy;

   logic [3:0]  cmd;
   logic        sel;
   logic        isNop;
   logic        normal;
   logic        busy;
   logic        allIdle;
   logic        lowEntry;
   logic        exec;
   logic        cmdRead;
   logic        cmdWrite;
   logic        cmdRw;
   logic        cmdAct;
   logic        cmdPre;
   logic        cmdRef;
   logic        cmdBst;
   logic        contBeat;
   logic        lastBeat;
   logic        endBurst;
   logic        apEnd;
   logic        memWe;
   logic [4:0]  accIdx;
   logic        pushRd;
   logic        selfEnt;
   logic        deepEnt;
   logic        pdEnt;
   logic        pdExit;
   logic        selfTick;

   // command decode
   assign cmd      = {link.csN, link.rasN, link.casN, link.weN};
   assign sel      = ~link.csN;
   assign isNop    = link.csN | (cmd == `CMD_NOP);
   assign normal   = (pwr_q == P_NORMAL);
   assign busy     = bActive_q | (|pipeV_q);
   assign allIdle  = ~(|bankOpen) & ~(|wrBusy);
   assign lowEntry = normal & ~link.cke & ~busy;
   assign exec     = normal & ckeReg_q & ~lowEntry;
   assign cmdRead  = exec & sel & (cmd == `CMD_READ);
   assign cmdWrite = exec & sel & (cmd == `CMD_WRITE);
   assign cmdRw    = cmdRead | cmdWrite;
   assign cmdAct   = exec & sel & (cmd == `CMD_ACT);
   assign cmdPre   = exec & sel & (cmd == `CMD_PRE);
   assign cmdRef   = exec & sel & (cmd == `CMD_REF);
   assign cmdBst   = exec & sel & (cmd == `CMD_BST);

   // burst progress; a suspended edge has exec low and freezes it
   assign contBeat = exec & bActive_q & ~cmdRw & ~cmdBst;
   assign lastBeat = contBeat & (bLeft_q == 3'h1);
   assign endBurst = (bActive_q & (cmdRw | cmdBst)) | lastBeat;
   assign apEnd    = endBurst & bAp_q;
   assign accIdx   = cmdRw ? {link.ba, link.addr[2:0]}
                           : {bBank_q, bCol_q};
   // data at an interrupting read edge is dropped, earlier edge stood
   assign memWe    = (cmdWrite | (contBeat & bWrite_q))
                     & ~link.dqm;
   assign pushRd   = cmdRead | (contBeat & ~bWrite_q);

   // power transitions
   assign selfEnt  = lowEntry & allIdle & sel
                     & (cmd == `CMD_REF);
   assign deepEnt  = lowEntry & allIdle & sel
                     & (cmd == `CMD_BST);
   assign pdEnt    = lowEntry & isNop;
   assign pdExit   = link.cke & isNop;
   assign selfTick = (pwr_q == P_SELF) & (selfTick_q == 12'h000);

   // storage, lost on deep power-down entry
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int k = 0; k < `MEM_WORDS; k++) begin
            mem_q[k] <= 16'h0000;
         end
      end else if (deepEnt) begin
         for (int k = 0; k < `MEM_WORDS; k++) begin
            mem_q[k] <= 16'h0000;
         end
      end else if (memWe) begin
         mem_q[accIdx] <= link.dqWr;
      end
   end

   // burst engine
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bActive_q <= 1'b0;
         bWrite_q  <= 1'b0;
         bAp_q     <= 1'b0;
         bBank_q   <= 2'h0;
         bCol_q    <= 3'h0;
         bLeft_q   <= 3'h0;
      end else if (cmdRw) begin
         bActive_q <= 1'b1;
         bWrite_q  <= cmdWrite;
         bAp_q     <= link.addr[10];
         bBank_q   <= link.ba;
         bCol_q    <= link.addr[2:0] + 3'h1;
         bLeft_q   <= 3'(BL - 1);
      end else if (cmdBst | lastBeat) begin
         bActive_q <= 1'b0;
      end else if (contBeat) begin
         bCol_q    <= bCol_q + 3'h1;
         bLeft_q   <= bLeft_q - 3'h1;
      end
   end

   // read pipeline of read_latency stages, held while suspended
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pipeV_q <= '0;
         for (int k = 0; k < RL; k++) begin
            pipeD_q[k] <= 16'h0000;
         end
      end else if (exec) begin
         pipeV_q[0] <= pushRd;
         pipeD_q[0] <= mem_q[accIdx];
         for (int k = 1; k < RL; k++) begin
            pipeV_q[k] <= pipeV_q[k-1];
            pipeD_q[k] <= pipeD_q[k-1];
         end
      end else if (!normal) begin
         pipeV_q <= '0;
      end
   end

   // per bank open flag and write recovery timer
   for (genvar i = 0; i < 4; i++) begin : g_bank
      logic       open_q;
      logic [3:0] tmr_q;
      logic       hit;
      logic       wrAp;
      logic       rdAp;
      logic       shut;
      assign hit  = (bBank_q == 2'(i));
      assign wrAp = apEnd & bWrite_q & hit;
      assign rdAp = apEnd & ~bWrite_q & hit;
      assign shut = (cmdPre & (link.addr[10] | (link.ba == 2'(i))))
                    | rdAp | (tmr_q == 4'h1);
      assign bankOpen[i] = open_q;
      assign wrBusy[i]   = (tmr_q != 4'h0);
      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n) begin
            open_q <= 1'b0;
            tmr_q  <= 4'h0;
         end else begin
            if (wrAp) begin
               tmr_q <= 4'(`WR_CYC);
            end else if (tmr_q != 4'h0) begin
               tmr_q <= tmr_q - 4'h1;
            end
            if (cmdAct & (link.ba == 2'(i))) begin
               open_q <= 1'b1;
            end else if (shut) begin
               open_q <= 1'b0;
            end
         end
      end
   end

   // power state
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pwr_q      <= P_NORMAL;
         activePd_q <= 1'b0;
         ckeReg_q   <= 1'b1;
      end else begin
         ckeReg_q <= link.cke;
         case (pwr_q)
            P_NORMAL: begin
               if (selfEnt) begin
                  pwr_q <= P_SELF;
               end else if (deepEnt) begin
                  pwr_q <= P_DEEP;
               end else if (pdEnt) begin
                  pwr_q      <= P_PDOWN;
                  activePd_q <= |bankOpen;
               end
            end
            P_PDOWN: begin
               if (pdExit) begin
                  pwr_q      <= P_NORMAL;
                  activePd_q <= 1'b0;
               end
            end
            P_SELF: begin
               if (link.cke) begin
                  pwr_q <= P_NORMAL;
               end
            end
            P_DEEP: begin
               if (link.cke) begin
                  pwr_q <= P_NORMAL;
               end
            end
            default: begin
               pwr_q <= P_NORMAL;
            end
         endcase
      end
   end

   // refresh row counter, internal tick in self refresh only
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         refRow_q   <= 12'h000;
         selfTick_q <= 12'h000;
      end else begin
         if (cmdRef | selfTick) begin
            refRow_q <= refRow_q + 12'h001;
         end
         if ((pwr_q != P_SELF) | selfTick) begin
            selfTick_q <= 12'(`REFI_CYC - 1);
         end else begin
            selfTick_q <= selfTick_q - 12'h001;
         end
      end
   end

   // status and read data outputs
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         suspended_q <= 1'b0;
         banksOut_q  <= 4'h0;
      end else begin
         suspended_q <= normal & ~ckeReg_q & busy;
         banksOut_q  <= bankOpen;
      end
   end

   assign powerMode   = pwr_q;
   assign activePd    = activePd_q;
   assign suspended   = suspended_q;
   assign refreshRow  = refRow_q;
   assign banksOpen   = banksOut_q;
   assign link.dqRd   = pipeD_q[RL-1];
   assign link.dqRdOe = pipeV_q[RL-1];
endmodule

// File: rtl/sdram_ctrl_end.sv
// sdram_ctrl_end: controller end, one access at a time, refresh, power
// assumes the memory end on the same mclk; user holds reqValid to reqAck
`timescale 1ns/1ps
`include "sdram_cfg.svh"
module sdram_ctrl_end (
   // clock and reset
   input  wire logic         mclk,
   input  wire logic         rst_n,
   // link to the memory
   sdram_link_if.ctrl        link,
   // access requests
   input  wire logic         reqValid,
   input  wire logic         reqWrite,
   input  wire logic         reqAutoPre,
   input  wire logic [1:0]   reqBank,
   input  wire logic [11:0]  reqRow,
   input  wire logic [8:0]   reqCol,
   input  wire logic [15:0]  reqData,
   output logic              reqAck,
   output logic              rdValid,
   output logic [15:0]       rdData,
   // power requests
   input  wire logic         pdReq,
   input  wire logic         srReq,
   input  wire logic         dpdReq,
   output logic              lowPower
);
   import sdram_pkg::*;

   ctl_e        st_q;
   ctl_e        ret_q;
   cnt_t        wait_q;
   cnt_t        minCnt_q;
   cnt_t        refCnt_q;
   logic        refDue_q;
   logic [1:0]  initLeft_q;
   logic [3:0]  cmd_q;
   logic        cke_q;
   logic        dqm_q;
   logic [1:0]  ba_q;
   logic [11:0] addr_q;
   logic [15:0] dqW_q;
   logic        dqOe_q;
   logic        ack_q;
   logic        wr_q;
   logic        ap_q;
   logic [8:0]  col_q;
   logic [15:0] data_q;
   logic [2:0]  rdCnt_q;
   logic        rdV_q;
   logic [15:0] rdD_q;
   logic        lowPower_q;

   logic        needRef;
   logic        refIssue;
   logic        srExit;
   logic        rdIssue;

   assign needRef  = refDue_q | (initLeft_q != 2'h0);
   assign refIssue = (st_q == C_REF);
   assign srExit   = (st_q == C_SREF) & (minCnt_q == 12'h000) & ~srReq;
   assign rdIssue  = (st_q == C_RW) & ~wr_q;

   // command sequencer
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= C_IDLE;
         ret_q <= C_IDLE;
         wait_q <= 12'h000;
         minCnt_q <= 12'h000;
         initLeft_q <= 2'h0;
         cmd_q <= `CMD_NOP;
         cke_q <= 1'b1;
         dqm_q <= 1'b1;
         ba_q <= 2'h0;
         addr_q <= 12'h000;
         dqW_q <= 16'h0000;
         dqOe_q <= 1'b0;
         ack_q <= 1'b0;
         wr_q <= 1'b0;
         ap_q <= 1'b0;
         col_q <= 9'h000;
         data_q <= 16'h0000;
      end else begin
         cmd_q  <= `CMD_NOP;
         dqOe_q <= 1'b0;
         dqm_q  <= 1'b1;
         ack_q  <= 1'b0;
         case (st_q)
            C_IDLE: begin
               if (needRef | dpdReq | srReq) begin
                  cmd_q  <= `CMD_PRE;
                  addr_q <= `A10_ALL;
                  wait_q <= 12'(`RP_CYC);
                  ret_q  <= needRef ? C_REF
                          : (dpdReq ? C_DENTER : C_SENTER);
                  st_q   <= C_WAIT;
               end else if (pdReq) begin
                  cke_q <= 1'b0;
                  st_q  <= C_PDN;
               end else if (reqValid) begin
                  cmd_q  <= `CMD_ACT;
                  ba_q   <= reqBank;
                  addr_q <= reqRow;
                  wr_q   <= reqWrite;
                  ap_q   <= reqAutoPre;
                  col_q  <= reqCol;
                  data_q <= reqData;
                  ack_q  <= 1'b1;
                  wait_q <= 12'(`RCD_CYC);
                  ret_q  <= C_RW;
                  st_q   <= C_WAIT;
               end
            end
            C_WAIT: begin
               if (wait_q <= 12'h001) begin
                  st_q <= ret_q;
               end else begin
                  wait_q <= wait_q - 12'h001;
               end
            end
            C_RW: begin
               cmd_q  <= wr_q ? `CMD_WRITE : `CMD_READ;
               addr_q <= {1'b0, ap_q, 1'b0, col_q};
               dqW_q  <= data_q;
               dqOe_q <= wr_q;
               dqm_q  <= 1'b0;
               wait_q <= ap_q
                  ? 12'(`BURST_LEN + `WR_CYC + `RP_CYC)
                  : 12'(`BURST_LEN + `WR_CYC);
               ret_q  <= ap_q ? C_IDLE : C_PRE;
               st_q   <= C_WAIT;
            end
            C_PRE: begin
               cmd_q  <= `CMD_PRE;
               addr_q <= 12'h000;
               wait_q <= 12'(`RP_CYC);
               ret_q  <= C_IDLE;
               st_q   <= C_WAIT;
            end
            C_REF: begin
               cmd_q <= `CMD_REF;
               if (initLeft_q != 2'h0) begin
                  initLeft_q <= initLeft_q - 2'h1;
               end
               wait_q <= 12'(`RFC_CYC);
               ret_q  <= C_IDLE;
               st_q   <= C_WAIT;
            end
            C_SENTER: begin
               cmd_q    <= `CMD_REF;
               cke_q    <= 1'b0;
               minCnt_q <= 12'(`RAS_CYC);
               st_q     <= C_SREF;
            end
            C_SREF: begin
               if (minCnt_q != 12'h000) begin
                  minCnt_q <= minCnt_q - 12'h001;
               end else if (!srReq) begin
                  cke_q  <= 1'b1;
                  wait_q <= 12'(`XSR_CYC);
                  ret_q  <= C_IDLE;
                  st_q   <= C_WAIT;
               end
            end
            C_DENTER: begin
               cmd_q <= `CMD_BST;
               cke_q <= 1'b0;
               st_q  <= C_DEEP;
            end
            C_DEEP: begin
               if (!dpdReq) begin
                  cke_q      <= 1'b1;
                  initLeft_q <= 2'h2;
                  wait_q     <= 12'(`XSR_CYC);
                  ret_q      <= C_IDLE;
                  st_q       <= C_WAIT;
               end
            end
            C_PDN: begin
               if (!pdReq | refDue_q) begin
                  cke_q <= 1'b1;
                  st_q  <= C_IDLE;
               end
            end
            default: begin
               st_q <= C_IDLE;
            end
         endcase
      end
   end

   // distributed refresh timer; a new due wins over the clear
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         refCnt_q <= 12'(`REFI_CYC);
         refDue_q <= 1'b0;
      end else if (srExit | (refCnt_q == 12'h000)) begin
         refCnt_q <= 12'(`REFI_CYC);
         refDue_q <= 1'b1;
      end else begin
         refCnt_q <= refCnt_q - 12'h001;
         if (refIssue) begin
            refDue_q <= 1'b0;
         end
      end
   end

   // read data capture read_latency after the command is sampled
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdCnt_q <= 3'h0;
         rdV_q   <= 1'b0;
         rdD_q   <= 16'h0000;
      end else begin
         rdV_q <= (rdCnt_q == 3'h1) & link.dqRdOe;
         if (rdCnt_q == 3'h1) begin
            rdD_q <= link.dqRd;
         end
         if (rdIssue) begin
            rdCnt_q <= 3'(`READ_LATENCY + 1);
         end else if (rdCnt_q != 3'h0) begin
            rdCnt_q <= rdCnt_q - 3'h1;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lowPower_q <= 1'b0;
      end else begin
         lowPower_q <= (st_q == C_PDN) | (st_q == C_SREF)
                       | (st_q == C_DEEP);
      end
   end

   assign {link.csN, link.rasN, link.casN, link.weN} = cmd_q;
   assign link.cke    = cke_q;
   assign link.dqm    = dqm_q;
   assign link.ba     = ba_q;
   assign link.addr   = addr_q;
   assign link.dqWr   = dqW_q;
   assign link.dqWrOe = dqOe_q;
   assign reqAck      = ack_q;
   assign rdValid     = rdV_q;
   assign rdData      = rdD_q;
   assign lowPower    = lowPower_q;
endmodule

// File: tb/sdram_link_checker.sv
// sdram_link_checker: timing relations on the link between the two ends
// assumes plain inputs wired from the link interface, one mclk domain
`timescale 1ns/1ps
`include "sdram_cfg.svh"
module sdram_link_checker (
   // clock and reset
   input wire logic        mclk,
   input wire logic        rst_n,
   // command side
   input wire logic        csN,
   input wire logic        rasN,
   input wire logic        casN,
   input wire logic        weN,
   input wire logic        cke,
   input wire logic        dqm,
   input wire logic [1:0]  ba,
   input wire logic [11:0] addr,
   // data side
   input wire logic [15:0] dqWr,
   input wire logic        dqWrOe,
   input wire logic [15:0] dqRd,
   input wire logic        dqRdOe
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   wire [3:0] cmd = {csN, rasN, casN, weN};
   logic      selfQ;
   // set on self refresh entry, cleared once cke is back high
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) selfQ <= 1'b0;
      else if (cmd == `CMD_REF && !cke) selfQ <= 1'b1;
      else if (cke) selfQ <= 1'b0;
   end
   refresh_quiet_a: assert property (cmd == `CMD_REF && cke |=>
      (cmd == `CMD_NOP) [*7]) else $error("command inside refresh time");
   refresh_prep_a: assert property (cmd == `CMD_REF |->
      $past(cmd) == `CMD_NOP && $past(cmd, 2) == `CMD_NOP)
      else $error("refresh too soon after command");
   self_exit_a: assert property ($rose(cke) && selfQ |->
      (cmd == `CMD_NOP) [*8]) else $error("command too soon after exit");
   self_hold_a: assert property (cmd == `CMD_REF && !cke |=>
      !cke [*4]) else $error("self refresh left too early");
   write_drive_a: assert property (dqWrOe |-> cmd == `CMD_WRITE)
      else $error("write data driven outside write");
   mask_open_a: assert property (!dqm |->
      cmd inside {`CMD_WRITE, `CMD_READ}) else $error("mask low wrongly");
   read_latency_a: assert property (cmd == `CMD_READ && cke |->
      ##2 dqRdOe) else $error("read data late");
   burst_len_a: assert property ($rose(dqRdOe) |->
      dqRdOe [*4] ##1 !dqRdOe) else $error("read burst length wrong");
endmodule

// File: tb/sdram_refresh_power_states_test.sv
// sdram_refresh_power_states_test: controller end facing memory end
// assumes both ends on one 100 MHz mclk; bench drives the user side
`timescale 1ns/1ps
module sdram_refresh_power_states_test;
   logic            mclk = 1'b0;
   logic            rst_n = 1'b0;
   logic            reqValid, reqWrite, reqAutoPre, reqAck, rdValid;
   logic            lowPower, activePd, suspended;
   logic [3:0]      banksOpen;
   logic [1:0]      reqBank;
   logic [2:0]      pwrReq;
   logic [11:0]     reqRow, refreshRow;
   logic [8:0]      reqCol;
   logic [15:0]     reqData, rdData;
   logic [15:0]     mdl [32];
   logic [15:0]     expQ [$];
   sdram_pkg::pwr_e powerMode;
   int              err_total, checks, i;
   always #5 mclk = ~mclk;
   sdram_link_if link ();
   sdram_mem_end sdram_mem_end_i (.mclk(mclk), .rst_n(rst_n), .link(link),
      .powerMode(powerMode), .activePd(activePd), .suspended(suspended),
      .refreshRow(refreshRow), .banksOpen(banksOpen));
   sdram_ctrl_end sdram_ctrl_end_i (.mclk(mclk), .rst_n(rst_n),
      .link(link), .reqValid(reqValid), .reqWrite(reqWrite),
      .reqAutoPre(reqAutoPre), .reqBank(reqBank), .reqRow(reqRow),
      .reqCol(reqCol), .reqData(reqData), .reqAck(reqAck),
      .rdValid(rdValid), .rdData(rdData), .pdReq(pwrReq[0]),
      .srReq(pwrReq[1]), .dpdReq(pwrReq[2]), .lowPower(lowPower));
   sdram_link_checker sdram_link_checker_i (.mclk(mclk), .rst_n(rst_n),
      .csN(link.csN), .rasN(link.rasN), .casN(link.casN), .weN(link.weN),
      .cke(link.cke), .dqm(link.dqm), .ba(link.ba), .addr(link.addr),
      .dqWr(link.dqWr), .dqWrOe(link.dqWrOe), .dqRd(link.dqRd),
      .dqRdOe(link.dqRdOe));
   task chk(input string n, input logic [15:0] s, input logic [15:0] e);
      checks++;
      if (s !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task finish_test();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // one access, held until the edge that samples reqAck high
   task acc(input logic w, input logic [4:0] a, input logic [15:0] d);
      int n;
      @(posedge mclk);
      reqValid <= 1'b1;
      reqWrite <= w;
      reqBank <= a[4:3];
      reqCol <= {6'h00, a[2:0]};
      reqData <= d;
      reqAutoPre <= 1'($urandom);
      reqRow <= 12'($urandom);
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (reqAck !== 1'b1 && n < 300);
      if (n >= 300) err_total++;
      @(posedge mclk);
      reqValid <= 1'b0;
      if (w) mdl[a] = d;
      else expQ.push_back(mdl[a]);
   endtask
   task pw(input int k);
      int n;
      @(posedge mclk);
      pwrReq <= 3'b001 << k;
      n = 0;
      while (lowPower !== 1'b1 && n < 500) begin
         @(negedge mclk);
         n++;
      end
      if (n >= 500) err_total++;
      repeat (8) @(negedge mclk);
      chk("powerMode", 16'(powerMode), 16'(k + 1));
      chk("activePd", 16'(activePd), 16'h0000);
      chk("suspended", 16'(suspended), 16'h0000);
      chk("banksOpen", 16'(banksOpen), 16'h0000);
      @(posedge mclk);
      pwrReq <= 3'b000;
      repeat (40) @(negedge mclk);
      chk("powerMode", 16'(powerMode), 16'h0000);
      if (k == 2) for (n = 0; n < 32; n++) mdl[n] = 16'h0000;
      $display("test power %0d done", k);
   endtask
   // read results taken off the queue as they appear
   always @(negedge mclk) begin
      if (rdValid === 1'b1) begin
         if (expQ.size() == 0) chk("rdValid", 16'h0001, 16'h0000);
         else chk("rdData", rdData, expQ.pop_front());
      end
   end
   initial begin
      #400000;
      err_total++;
      finish_test();
   end
   initial begin
      {reqValid, reqWrite, reqAutoPre, reqBank, pwrReq} = '0;
      {reqRow, reqCol, reqData} = '0;
      for (i = 0; i < 32; i++) mdl[i] = 16'h0000;
      i = $urandom(32'hF5CC1500);
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (1600) @(posedge mclk);
      chk("refreshRow", 16'(refreshRow), 16'h0001);
      $display("test refresh done");
      for (i = 0; i < 32; i++) acc(1'b1, 5'(i), 16'($urandom));
      for (i = 31; i >= 0; i--) acc(1'b0, 5'(i), 16'h0000);
      repeat (20) @(posedge mclk);
      $display("test data done");
      for (i = 0; i < 3; i++) pw(i);
      for (i = 0; i < 4; i++) acc(1'b0, 5'(i * 9), 16'h0000);
      repeat (20) @(posedge mclk);
      chk("expQ", 16'(expQ.size()), 16'h0000);
      $display("test deep data done");
      finish_test();
   end
endmodule
